// ---- adc_bus_control_interface.sv ----
// Converter control: start/read decode, busy status and three-state result bus.
// Assumes host pins synchronous to ref_clk and a sampled analog value.
// Notes on behaviour
// - Converting: bus off, status high, pins ignored
// - Write with both selects low starts conversion
// - Idle read with selects low drives result
// - Any select high: nothing happens, bus off
// - Status high busy, low when idle selected
// - Format pin alone chooses output coding; polarity pin has no effect
// - Out-of-span input holds the extreme code
// - Eight-bit bus, bit 0 least significant
`default_nettype none
module adc_bus_control_interface (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire adc_ctrl_pkg::host_ctrl_t host,
  input  wire adc_ctrl_pkg::fmt_sel_t   fmt,
  input  wire logic signed [9:0]       sample,
  output logic [7:0]                   result_out,
  output logic [7:0]                   result_oe,
  output logic                         status
);
  typedef enum logic {IDLE, CONVERT} conv_state_t;
  conv_state_t state_r, state_nxt;
  logic [8:0]  cnt_r, cnt_nxt;
  logic [7:0]  result_r, result_nxt;
  logic [7:0]  code;
  logic        selected, start, rd;
  logic        conv_done;
  logic [8:0]  busy_cnt_r, busy_cnt_nxt;

  // Shared by the decode and by the checks below
  function automatic logic both_selected(input adc_ctrl_pkg::host_ctrl_t h);
    return !h.cs_n && !h.ce_n;
  endfunction

  function automatic logic above_span(input logic signed [9:0] s);
    return s > $signed(adc_ctrl_pkg::SPAN_MAX);
  endfunction

  function automatic logic below_span(input logic signed [9:0] s);
    return s < 10'sd0;
  endfunction

  adc_code_map u_map (
    .ref_clk (ref_clk),
    .reset   (reset),
    .sample  (sample),
    .fmt     (fmt),
    .code    (code)
  );

  assign selected  = both_selected(host);
  assign start     = selected && !host.rw;
  assign rd        = selected && host.rw;
  assign conv_done = (state_r == CONVERT) && (cnt_r == 9'h000);

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    result_nxt = result_r;
    case (state_r)
      IDLE: begin
        if (start) begin
          state_nxt = CONVERT;
          cnt_nxt   = adc_ctrl_pkg::CONV_CNT_INIT;
        end
      end
      CONVERT: begin
        // Pins ignored here; a second start cannot retrigger
        if (conv_done) begin
          state_nxt  = IDLE;
          result_nxt = code;
        end else begin
          cnt_nxt = cnt_r - 9'h001;
        end
      end
      default: state_nxt = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r  <= IDLE;
      cnt_r    <= 9'h000;
      result_r <= adc_ctrl_pkg::RESULT_RESET;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      result_r <= result_nxt;
    end
  end

  // Check-only busy counter, kept apart from cnt_r so the length check is real
  always_comb begin
    busy_cnt_nxt = 9'h000;
    if (status) begin
      busy_cnt_nxt = busy_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_cnt_r <= 9'h000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  // Busy shown as high; deselected idle reads low, which is allowed
  assign status     = (state_r == CONVERT);
  assign result_out = result_r;
  // Drive only on an idle selected read
  assign result_oe  = {8{rd && state_r == IDLE}};

  a_busy_float: assert property (
    @(posedge ref_clk) disable iff (reset)
    status |-> result_oe == 8'h00)
    else $error("bus driven during conversion");

  a_start_busy: assert property (
    @(posedge ref_clk) disable iff (reset)
    (start && !status) |=> status[*8])
    else $error("start did not raise status");

  a_conv_len: assert property (
    @(posedge ref_clk) disable iff (reset)
    (status && busy_cnt_r == adc_ctrl_pkg::CONV_CNT_INIT) |=> !status)
    else $error("conversion ran past its length");

  a_conv_hold: assert property (
    @(posedge ref_clk) disable iff (reset)
    (status && busy_cnt_r != adc_ctrl_pkg::CONV_CNT_INIT) |=> status)
    else $error("conversion ended early");

  a_cnt_range: assert property (
    @(posedge ref_clk) disable iff (reset)
    status |-> cnt_r <= adc_ctrl_pkg::CONV_CNT_INIT)
    else $error("conversion counter out of range");

  a_cnt_load: assert property (
    @(posedge ref_clk) disable iff (reset)
    (start && !status) |=> cnt_r == adc_ctrl_pkg::CONV_CNT_INIT)
    else $error("conversion counter not loaded on start");

  a_write_float: assert property (
    @(posedge ref_clk) disable iff (reset)
    start |-> result_oe == 8'h00)
    else $error("bus driven during a start");

  a_read_drive: assert property (
    @(posedge ref_clk) disable iff (reset)
    (rd && !status) |-> result_oe == 8'hff && result_out == result_r)
    else $error("idle read did not drive result");

  a_read_noop: assert property (
    @(posedge ref_clk) disable iff (reset)
    (rd && !status) |=> !status)
    else $error("read started a conversion");

  a_oe_read_only: assert property (
    @(posedge ref_clk) disable iff (reset)
    (result_oe == 8'hff) |-> (rd && !status))
    else $error("bus driven outside an idle read");

  a_oe_whole: assert property (
    @(posedge ref_clk) disable iff (reset)
    (result_oe == 8'h00 || result_oe == 8'hff))
    else $error("bus enables split across bits");

  a_desel_float: assert property (
    @(posedge ref_clk) disable iff (reset)
    !both_selected(host) |-> result_oe == 8'h00)
    else $error("bus driven while deselected");

  a_desel_noop: assert property (
    @(posedge ref_clk) disable iff (reset)
    (!status && !both_selected(host)) |=> !status)
    else $error("conversion started while deselected");

  a_status_idle: assert property (
    @(posedge ref_clk) disable iff (reset)
    (selected && state_r == IDLE) |-> !status)
    else $error("status high while idle and selected");

  a_reset_idle: assert property (
    @(posedge ref_clk)
    reset |=> (!status && result_out == adc_ctrl_pkg::RESULT_RESET))
    else $error("reset did not return to idle");

  a_result_load: assert property (
    @(posedge ref_clk) disable iff (reset)
    conv_done |=> result_r == $past(code))
    else $error("result not captured at end of conversion");

  a_result_hold: assert property (
    @(posedge ref_clk) disable iff (reset)
    !conv_done |=> $stable(result_out))
    else $error("result changed outside end of conversion");

  a_sat_top: assert property (
    @(posedge ref_clk) disable iff (reset)
    (conv_done && above_span(sample) && !fmt.format_twos) |=> result_out == 8'hff)
    else $error("straight result did not hold top code");

  a_sat_bottom: assert property (
    @(posedge ref_clk) disable iff (reset)
    (conv_done && below_span(sample) && !fmt.format_twos) |=> result_out == 8'h00)
    else $error("straight result did not hold bottom code");

  a_sat_top_twos: assert property (
    @(posedge ref_clk) disable iff (reset)
    (conv_done && above_span(sample) && fmt.format_twos) |=> result_out == 8'h7f)
    else $error("two's complement result did not hold top code");

  a_sat_bottom_twos: assert property (
    @(posedge ref_clk) disable iff (reset)
    (conv_done && below_span(sample) && fmt.format_twos)
      |=> result_out == adc_ctrl_pkg::CODE_MSB)
    else $error("two's complement result did not hold bottom code");

  a_twos_full: assert property (
    @(posedge ref_clk) disable iff (reset)
    (conv_done && fmt.format_twos && sample == $signed(adc_ctrl_pkg::SPAN_MAX))
      |=> result_out == 8'h7f)
    else $error("two's complement full scale code wrong");
endmodule // adc_bus_control_interface
`default_nettype wire

// ---- adc_ctrl_pkg.sv ----
// Package: shared types and constants of the converter control block.
// Assumes a single 20 MHz clock; no bus, all controls are plain ports.
`default_nettype none
package adc_ctrl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CONV_TIME_NS  = 10000;
  // Longest conversion time, rounded down to whole cycles
  localparam int unsigned CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [8:0]  CONV_CNT_INIT = 9'(CONV_CYCLES - 1);
  localparam logic [7:0]  RESULT_RESET  = 8'h00;
  localparam logic [7:0]  CODE_MSB      = 8'h80;
  localparam logic [9:0]  SPAN_MAX      = 10'h0ff;

  // Host control pins, sampled as synchronous
  typedef struct packed {
    logic rw;
    logic cs_n;
    logic ce_n;
  } host_ctrl_t;

  // Static format pins
  typedef struct packed {
    logic polarity_select;
    logic format_twos;
  } fmt_sel_t;

  typedef enum logic [1:0] {UNI_STRAIGHT, BIP_OFFSET, UNI_TWOS, BIP_TWOS} fmt_mode_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// ---- adc_code_map.sv ----
// Code mapper: saturates the raw sample and applies the output format.
// Assumes the sample is a signed count relative to the bottom of the span.
`default_nettype none
module adc_code_map (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic signed [9:0]     sample,
  input  wire adc_ctrl_pkg::fmt_sel_t fmt,
  output logic [7:0]                 code
);
  logic [7:0] sat;
  // Out-of-span input pins to the end code, never wraps
  always_comb begin
    if (sample < 10'sd0) begin
      sat = 8'h00;
    end else if (sample > $signed(adc_ctrl_pkg::SPAN_MAX)) begin
      sat = 8'hff;
    end else begin
      sat = sample[7:0];
    end
  end

  // Straight/offset in, MSB flip gives two's complement
  always_comb begin
    case (adc_ctrl_pkg::fmt_mode_t'({fmt.format_twos, fmt.polarity_select}))
      adc_ctrl_pkg::UNI_STRAIGHT: code = sat;
      adc_ctrl_pkg::BIP_OFFSET:   code = sat;
      adc_ctrl_pkg::UNI_TWOS:     code = sat ^ adc_ctrl_pkg::CODE_MSB;
      adc_ctrl_pkg::BIP_TWOS:     code = sat ^ adc_ctrl_pkg::CODE_MSB;
      default:                    code = sat;
    endcase
  end

  a_sat_high: assert property (
    @(posedge ref_clk) disable iff (reset)
    (sample > $signed(adc_ctrl_pkg::SPAN_MAX) && !fmt.format_twos) |-> code == 8'hff)
    else $error("over-range input did not saturate high");
  a_sat_low: assert property (
    @(posedge ref_clk) disable iff (reset)
    (sample < 10'sd0 && fmt.format_twos) |-> code == 8'h80)
    else $error("under-range input did not saturate low");
  a_twos_map: assert property (
    @(posedge ref_clk) disable iff (reset)
    (fmt.format_twos && sample == 10'sd128) |-> code == 8'h00)
    else $error("two's complement midscale wrong");
endmodule // adc_code_map
`default_nettype wire

// ---- adc_host_model.sv ----
// Host model: turns a bench command into read/write and select levels.
// Assumes commands change only at falling edges.
`default_nettype none
module adc_host_model (
  input  wire logic [1:0]              cmd,
  output var adc_ctrl_pkg::host_ctrl_t host
);
  // 0 idle, 1 start, 2 read, 3 read with one select high
  always_comb begin
    host.rw   = cmd[1];
    host.cs_n = (cmd == 2'd0);
    host.ce_n = (cmd == 2'd3);
  end
endmodule // adc_host_model
`default_nettype wire

// ---- adc_bus_control_interface_bench.sv ----
// Bench: corner and random conversions in all four formats.
// Assumes the host model drives the pins; inputs change at falling edges.
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module adc_bus_control_interface_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     ref_clk = 1'b0;
  logic                     reset   = 1'b1;
  logic [1:0]               cmd     = 2'h0;
  adc_ctrl_pkg::fmt_sel_t   fmt     = '0;
  logic signed [9:0]        sample  = '0;
  logic [7:0]               result_out;
  logic [7:0]               result_oe;
  logic                     status;
  adc_ctrl_pkg::host_ctrl_t host;
  logic [31:0]              lfsr = 32'hfab631ef;
  int                       fail_count = 0;
  int                       cmp_count  = 0;
  int                       n;
  adc_host_model u_host (.cmd(cmd), .host(host));
  adc_bus_control_interface u_dut (.ref_clk(ref_clk), .reset(reset), .host(host),
    .fmt(fmt), .sample(sample), .result_out(result_out), .result_oe(result_oe),
    .status(status));
  function automatic logic [31:0] next_rnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Clamp, then flip the top bit for two's complement
  function automatic logic [7:0] expect_code(input logic signed [9:0] s, input logic twos);
    logic [7:0] c;
    c = (s < 0) ? 8'h00 : (s > 10'sh0ff) ? 8'hff : s[7:0];
    return c ^ (twos ? 8'h80 : 8'h00);
  endfunction
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic convert(input logic signed [9:0] s, input logic [1:0] f);
    sample = s;
    fmt = f;
    cmd = 2'h1;
    @(negedge ref_clk);
    // Read pins held during busy must be ignored
    cmd = 2'h2;
    n = 0;
    while (status === 1'b1 && n < 300) begin
      `CHK("oe_busy", 8'h00, result_oe)
      n++;
      @(negedge ref_clk);
    end
    `CHK("busy_len", int'(adc_ctrl_pkg::CONV_CYCLES), n)
    `CHK("oe_read", 8'hff, result_oe)
    `CHK("code", expect_code(s, f[0]), result_out)
    cmd = 2'h3;
    #1;
    `CHK("oe_desel", 8'h00, result_oe)
    @(negedge ref_clk);
    cmd = 2'h0;
    @(negedge ref_clk);
    `CHK("idle", 1'b0, status)
  endtask
  initial forever #25 ref_clk = ~ref_clk;
  // Runs take about 250 us; a hang is cut at 2 ms
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    cmd = 2'h2;
    @(negedge ref_clk);
    `CHK("rst_oe", 8'hff, result_oe)
    `CHK("rst_code", adc_ctrl_pkg::RESULT_RESET, result_out)
    `CHK("rst_idle", 1'b0, status)
    for (int i = 0; i < 4; i++) begin
      convert(-10'sh005, 2'(i));
      convert(10'sh12c, 2'(i));
      convert(10'sh0ff, 2'(i));
    end
    // Reset in mid-conversion must abort it and clear the result
    cmd = 2'h1;
    @(negedge ref_clk);
    cmd = 2'h0;
    repeat (5) @(negedge ref_clk);
    `CHK("busy_mid", 1'b1, status)
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    `CHK("mid_idle", 1'b0, status)
    `CHK("mid_code", adc_ctrl_pkg::RESULT_RESET, result_out)
    for (int i = 0; i < 12; i++) begin
      lfsr = next_rnd(lfsr);
      convert(lfsr[9:0], lfsr[11:10]);
    end
    summarize();
  end
endmodule // adc_bus_control_interface_bench
`default_nettype wire
